// file: pkg/sepp_defines.svh
/*
 * Constants of the four-wire serial programming port: word sizes, command
 * field positions, page size and write timing.
 * Assumes the user includes it by bare name; holds definitions only.
 */
`ifndef SEPP_DEFINES_SVH
`define SEPP_DEFINES_SVH

// ****************************************************************
// word layout
// ****************************************************************
`define SEPP_WORD_BITS 32
`define SEPP_BYTE_BITS 8
`define SEPP_PAGE_BIT 31
`define SEPP_ADDR_HI 17
`define SEPP_ADDR_LO 8
`define SEPP_ADDR_BITS 10
`define SEPP_DATA_HI 7
`define SEPP_DATA_LO 0
`define SEPP_OP_HI 30
`define SEPP_OP_LO 18
`define SEPP_PAGE_BYTES 16
`define SEPP_LAST_PAGE_IDX 4'hF

// ****************************************************************
// encodings of the separately agreed command table
// ****************************************************************
`define SEPP_OP_WRITE 13'h0001
`define SEPP_OP_READ 13'h0002
`define SEPP_RESP_OK 32'h00000000

// ****************************************************************
// timing: write time in ns, programmer clock half period minus one in cycles
// ****************************************************************
`define SEPP_CLK_NS 4
`define SEPP_WRITE_NS 5000
`define SEPP_WRITE_CYC ((`SEPP_WRITE_NS + `SEPP_CLK_NS - 1) / `SEPP_CLK_NS)
`define SEPP_HALF_CYC 8'h04
`define SEPP_ACCESS_CYC 8'h02

`endif

// file: pkg/sepp_pkg.sv
/*
 * Types of the serial programming port.
 * Assumes sepp_defines.svh is available on the include path.
 */
`include "sepp_defines.svh"

package sepp_pkg;

	// ****************************************************************
	// device side states
	// ****************************************************************
	typedef enum logic [1:0] {
		SEPP_DEV_SHIFT = 2'b00,
		SEPP_DEV_LATCH = 2'b01,
		SEPP_DEV_BUSY = 2'b10
	} sepp_dev_state_t;

	// ****************************************************************
	// programmer side states
	// ****************************************************************
	typedef enum logic [2:0] {
		SEPP_PRG_IDLE = 3'b000,
		SEPP_PRG_SHIFT = 3'b001,
		SEPP_PRG_PULSE = 3'b010,
		SEPP_PRG_WAIT = 3'b011,
		SEPP_PRG_DONE = 3'b100
	} sepp_prg_state_t;

endpackage : sepp_pkg

// file: pkg/sepp_if.sv
/*
 * Four pins between programmer and device.
 * Assumes the bench joins both ends through this interface.
 */
`timescale 1ns/10ps

interface sepp_if;
	logic latch_pin;
	logic cmd_in_pin;
	logic resp_out_pin;
	logic serial_clock_pin;

	modport device (
		input latch_pin,
		input cmd_in_pin,
		output resp_out_pin,
		input serial_clock_pin
	);

	modport programmer (
		output latch_pin,
		output cmd_in_pin,
		input resp_out_pin,
		output serial_clock_pin
	);
endinterface : sepp_if

// file: core/sepp_sync.sv
/*
 * Two-flop synchroniser with rising edge detect on the synchronised level.
 * Assumes an asynchronous pin input and clk_sys.
 */
`timescale 1ns/10ps

module sepp_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// pin and result
	input wire logic pinIn,
	output logic level,
	output logic rise
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} sepp_sync_state_t;

	sepp_sync_state_t cur;
	sepp_sync_state_t next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.meta = pinIn;
		next_cur.sync = cur.meta;
		next_cur.last = cur.sync;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign level = cur.sync;
	assign rise = cur.sync & ~cur.last;
endmodule : sepp_sync

// file: core/sepp_device.sv
/*
 * Device end of the serial programming port: shifts commands in, responses
 * out, holds a 1 KiB code memory with byte and 16-byte page writes.
 * Assumes pins come from another domain; reset is the external reset.
 */
`timescale 1ns/10ps
`include "sepp_defines.svh"

// Function
// - four wires: latch, command, response, clock
// - 32-bit command and response words
// - stays in programming mode until reset
// - programmer raises latch before clocking command
// - command shifted MSB first, bit 31
// - one previous-response bit per command bit
// - programmer samples response after access delay
// - programmer ignores first response word
// - latch low then exactly two clock pulses
// - response low by second edge during write
// - response high on completion; programmer waits
// - page mode writes 16 bytes at once
// - bit 31 set selects page mode
// - address in bits 17..8, page aligned
// - data byte in bits 7..0
// - further page bytes: 8 bits, two pulses
// - page write starts at sixteenth byte latch
// - programmer writes only whole pages
module sepp_device (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// link
	sepp_if.device link,
	// user side
	output logic progMode,
	output logic writeStrobe,
	output logic [`SEPP_ADDR_BITS-1:0] writeAddr,
	output logic [`SEPP_BYTE_BITS-1:0] writeData
);
	typedef struct packed {
		sepp_pkg::sepp_dev_state_t state;
		logic [`SEPP_WORD_BITS-1:0] shiftIn;
		logic [`SEPP_WORD_BITS-1:0] shiftOut;
		logic [`SEPP_WORD_BITS-1:0] resp;
		logic [5:0] bitCount;
		logic [1:0] pulses;
		logic pageActive;
		logic [3:0] pageIdx;
		logic [`SEPP_ADDR_BITS-1:0] addr;
		logic [`SEPP_BYTE_BITS*`SEPP_PAGE_BYTES-1:0] pageBuf;
		logic [15:0] busyCount;
		logic [3:0] wrIdx;
		logic wrRun;
		logic respOut;
		logic progMode;
		logic writeStrobe;
		logic [`SEPP_ADDR_BITS-1:0] writeAddr;
		logic [`SEPP_BYTE_BITS-1:0] writeData;
	} sepp_dev_t;

	sepp_dev_t cur;
	sepp_dev_t next_cur;
	logic [`SEPP_BYTE_BITS-1:0] mem [0:(1<<`SEPP_ADDR_BITS)-1];
	logic latchLvl;
	logic cmdLvl;
	logic clkRise;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	sepp_sync syncLatch (.clk_sys(clk_sys), .reset(reset),
		.pinIn(link.latch_pin), .level(latchLvl), .rise());
	sepp_sync syncCmd (.clk_sys(clk_sys), .reset(reset),
		.pinIn(link.cmd_in_pin), .level(cmdLvl), .rise());
	sepp_sync syncClk (.clk_sys(clk_sys), .reset(reset),
		.pinIn(link.serial_clock_pin), .level(), .rise(clkRise));

	function automatic logic [`SEPP_BYTE_BITS-1:0] pageByte(
		input logic [`SEPP_BYTE_BITS*`SEPP_PAGE_BYTES-1:0] buffer,
		input logic [3:0] idx);
		pageByte = buffer[idx*`SEPP_BYTE_BITS +: `SEPP_BYTE_BITS];
	endfunction : pageByte

	// ****************************************************************
	// protocol engine
	// ****************************************************************
	always_comb begin
		logic [`SEPP_WORD_BITS-1:0] cmd;
		cmd = cur.shiftIn;
		next_cur = cur;
		next_cur.writeStrobe = 1'b0;
		next_cur.progMode = 1'b1;
		case (cur.state)
			sepp_pkg::SEPP_DEV_SHIFT: begin
				if (latchLvl && clkRise) begin
					// MSB first in, previous response out
					next_cur.shiftIn = {cur.shiftIn[`SEPP_WORD_BITS-2:0],
						cmdLvl};
					next_cur.shiftOut = {cur.shiftOut[`SEPP_WORD_BITS-2:0],
						1'b0};
					next_cur.respOut = cur.shiftOut[`SEPP_WORD_BITS-1];
					next_cur.bitCount = cur.bitCount + 6'h01;
				end else if (!latchLvl && cur.bitCount != 6'h00) begin
					next_cur.state = sepp_pkg::SEPP_DEV_LATCH;
					next_cur.pulses = 2'h0;
				end
			end
			sepp_pkg::SEPP_DEV_LATCH: begin
				if (clkRise) begin
					next_cur.pulses = cur.pulses + 2'h1;
					if (cur.pulses == 2'h0) begin
						next_cur.respOut = 1'b1;
						if (cur.pageActive) begin
							// continuation byte, no command word
							next_cur.pageBuf[cur.pageIdx*`SEPP_BYTE_BITS +:
								`SEPP_BYTE_BITS] =
								cmd[`SEPP_BYTE_BITS-1:0];
							next_cur.pageIdx = cur.pageIdx + 4'h1;
							next_cur.respOut = 1'b0;
							if (cur.pageIdx == `SEPP_LAST_PAGE_IDX) begin
								next_cur.wrRun = 1'b1;
								next_cur.wrIdx = 4'h0;
								next_cur.pageActive = 1'b0;
							end
						end else if (cmd[`SEPP_OP_HI:`SEPP_OP_LO] ==
							`SEPP_OP_WRITE) begin
							next_cur.addr =
								cmd[`SEPP_ADDR_HI:`SEPP_ADDR_LO];
							next_cur.respOut = 1'b0;
							if (cmd[`SEPP_PAGE_BIT]) begin
								next_cur.pageActive = 1'b1;
								next_cur.pageBuf[`SEPP_BYTE_BITS-1:0] =
									cmd[`SEPP_DATA_HI:`SEPP_DATA_LO];
								next_cur.pageIdx = 4'h1;
								next_cur.resp = `SEPP_RESP_OK;
							end else begin
								next_cur.writeStrobe = 1'b1;
								next_cur.writeAddr =
									cmd[`SEPP_ADDR_HI:`SEPP_ADDR_LO];
								next_cur.writeData =
									cmd[`SEPP_DATA_HI:`SEPP_DATA_LO];
								next_cur.resp = `SEPP_RESP_OK;
							end
						end else if (cmd[`SEPP_OP_HI:`SEPP_OP_LO] ==
							`SEPP_OP_READ) begin
							next_cur.resp = {cmd[`SEPP_WORD_BITS-1:8],
								mem[cmd[`SEPP_ADDR_HI:`SEPP_ADDR_LO]]};
						end else begin
							next_cur.resp = `SEPP_RESP_OK;
						end
					end else begin
						// second pulse ends the cycle
						next_cur.shiftOut = cur.resp;
						next_cur.bitCount = 6'h00;
						next_cur.shiftIn = '0;
						next_cur.busyCount = 16'(`SEPP_WRITE_CYC);
						next_cur.state = cur.respOut ?
							sepp_pkg::SEPP_DEV_SHIFT :
							sepp_pkg::SEPP_DEV_BUSY;
					end
				end
			end
			sepp_pkg::SEPP_DEV_BUSY: begin
				// page bytes ack after a short busy; page write waits long
				if (cur.wrRun) begin
					next_cur.writeStrobe = 1'b1;
					next_cur.writeAddr = cur.addr | {6'h00, cur.wrIdx};
					next_cur.writeData = pageByte(cur.pageBuf, cur.wrIdx);
					next_cur.wrIdx = cur.wrIdx + 4'h1;
					if (cur.wrIdx == `SEPP_LAST_PAGE_IDX) begin
						next_cur.wrRun = 1'b0;
					end
				end else if (cur.pageActive ||
					cur.busyCount == 16'h0000) begin
					next_cur.respOut = 1'b1;
					next_cur.state = sepp_pkg::SEPP_DEV_SHIFT;
				end else begin
					next_cur.busyCount = cur.busyCount - 16'h0001;
				end
			end
			default: begin
				next_cur.state = sepp_pkg::SEPP_DEV_SHIFT;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cur <= '0;
			cur.respOut <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// ****************************************************************
	// code memory
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (cur.writeStrobe) begin
			mem[cur.writeAddr] <= cur.writeData;
		end
	end

	assign link.resp_out_pin = cur.respOut;
	assign progMode = cur.progMode;
	assign writeStrobe = cur.writeStrobe;
	assign writeAddr = cur.writeAddr;
	assign writeData = cur.writeData;
endmodule : sepp_device

// file: core/sepp_programmer.sv
/*
 * Programmer end: on a start pulse sends one 32-bit word, or a byte when in
 * page continuation, and returns the response word read meanwhile.
 * Assumes the response pin comes from another domain.
 */
`timescale 1ns/10ps
`include "sepp_defines.svh"

module sepp_programmer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// link
	sepp_if.programmer link,
	// user side
	input wire logic start,
	input wire logic byteOnly,
	input wire logic [`SEPP_WORD_BITS-1:0] cmdWord,
	output logic ready,
	output logic done,
	output logic [`SEPP_WORD_BITS-1:0] respWord
);
	typedef struct packed {
		sepp_pkg::sepp_prg_state_t state;
		logic [`SEPP_WORD_BITS-1:0] shiftOut;
		logic [`SEPP_WORD_BITS-1:0] shiftIn;
		logic [5:0] bitsLeft;
		logic [1:0] pulses;
		logic [7:0] timer;
		logic sclk;
		logic latch;
		logic pending;
		logic ready;
		logic done;
		logic [`SEPP_WORD_BITS-1:0] respWord;
	} sepp_prg_t;

	sepp_prg_t cur;
	sepp_prg_t next_cur;
	logic respLvl;

	sepp_sync syncResp (.clk_sys(clk_sys), .reset(reset),
		.pinIn(link.resp_out_pin), .level(respLvl), .rise());

	always_comb begin
		next_cur = cur;
		next_cur.done = 1'b0;
		if (cur.timer != 8'h00) begin
			next_cur.timer = cur.timer - 8'h01;
		end
		case (cur.state)
			sepp_pkg::SEPP_PRG_IDLE: begin
				next_cur.ready = 1'b1;
				// next command only with response high
				if (start && respLvl) begin
					next_cur.ready = 1'b0;
					next_cur.latch = 1'b1;
					next_cur.shiftOut = byteOnly ?
						{cmdWord[7:0], 24'h000000} : cmdWord;
					next_cur.bitsLeft = byteOnly ? 6'h08 : 6'h20;
					next_cur.timer = `SEPP_HALF_CYC;
					next_cur.state = sepp_pkg::SEPP_PRG_SHIFT;
				end
			end
			sepp_pkg::SEPP_PRG_SHIFT: begin
				if (cur.timer == 8'h00) begin
					next_cur.timer = `SEPP_HALF_CYC;
					if (!cur.sclk) begin
						// response bit settled over a full low phase
						if (cur.pending) begin
							next_cur.shiftIn = {cur.shiftIn[30:0], respLvl};
							next_cur.pending = 1'b0;
						end
						if (cur.bitsLeft == 6'h00) begin
							next_cur.latch = 1'b0;
							next_cur.pulses = 2'h0;
							next_cur.state = sepp_pkg::SEPP_PRG_PULSE;
						end else begin
							next_cur.sclk = 1'b1;
						end
					end else begin
						next_cur.sclk = 1'b0;
						next_cur.pending = 1'b1;
						next_cur.shiftOut = {cur.shiftOut[30:0], 1'b0};
						next_cur.bitsLeft = cur.bitsLeft - 6'h01;
					end
				end
			end
			sepp_pkg::SEPP_PRG_PULSE: begin
				if (cur.timer == 8'h00) begin
					next_cur.timer = `SEPP_HALF_CYC;
					next_cur.sclk = ~cur.sclk;
					if (cur.sclk) begin
						next_cur.pulses = cur.pulses + 2'h1;
						if (cur.pulses == 2'h1) begin
							next_cur.timer = 8'h10;
							next_cur.state = sepp_pkg::SEPP_PRG_WAIT;
						end
					end
				end
			end
			sepp_pkg::SEPP_PRG_WAIT: begin
				if (cur.timer == 8'h00 && respLvl) begin
					next_cur.state = sepp_pkg::SEPP_PRG_DONE;
				end
			end
			sepp_pkg::SEPP_PRG_DONE: begin
				next_cur.done = 1'b1;
				next_cur.respWord = cur.shiftIn;
				next_cur.ready = 1'b1;
				next_cur.state = sepp_pkg::SEPP_PRG_IDLE;
			end
			default: begin
				next_cur.state = sepp_pkg::SEPP_PRG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign link.latch_pin = cur.latch;
	assign link.cmd_in_pin = cur.shiftOut[`SEPP_WORD_BITS-1];
	assign link.serial_clock_pin = cur.sclk;
	assign ready = cur.ready;
	assign done = cur.done;
	assign respWord = cur.respWord;
endmodule : sepp_programmer

// file: tb/sepp_link_sva.sv
/*
 * Checker for the four link pins between programmer and device ends.
 * Assumes the bench hands it the interface signals, clk_sys and reset.
 */
`timescale 1ns/10ps
`include "sepp_defines.svh"

module sepp_link_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// link pins
	input wire logic latch_pin,
	input wire logic cmd_in_pin,
	input wire logic resp_out_pin,
	input wire logic serial_clock_pin
);
	logic prevClock;
	logic prevLatch;
	logic framed;
	logic [5:0] bitCnt;
	logic [1:0] pulseCnt;
	logic [31:0] shiftWord;
	logic clockRise;
	logic isWrite;

	// ****************************************************************
	// frame tracking
	// ****************************************************************
	assign clockRise = serial_clock_pin && !prevClock;
	assign isWrite = (bitCnt == 6'h08) ||
		(shiftWord[`SEPP_OP_HI:`SEPP_OP_LO] == `SEPP_OP_WRITE);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prevClock <= 1'b0;
			prevLatch <= 1'b0;
			framed <= 1'b0;
			bitCnt <= 6'h00;
			pulseCnt <= 2'h0;
			shiftWord <= 32'h00000000;
		end else begin
			prevClock <= serial_clock_pin;
			prevLatch <= latch_pin;
			framed <= framed | (prevLatch && !latch_pin);
			if (latch_pin && !prevLatch) begin
				bitCnt <= 6'h00;
				pulseCnt <= 2'h0;
			end else if (latch_pin && clockRise) begin
				bitCnt <= bitCnt + 6'h01;
				shiftWord <= {shiftWord[30:0], cmd_in_pin};
			end else if (clockRise && pulseCnt != 2'h3) begin
				pulseCnt <= pulseCnt + 2'h1;
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	clk_high_a: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(serial_clock_pin) |-> serial_clock_pin[*5] ##1 !serial_clock_pin)
		else $error("serial clock high phase not five cycles");
	clk_low_a: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(serial_clock_pin) |-> !serial_clock_pin[*5])
		else $error("serial clock low phase too short");
	cmd_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
		serial_clock_pin && $past(serial_clock_pin) |-> $stable(cmd_in_pin))
		else $error("command bit moved while clock high");
	latch_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
		serial_clock_pin && $past(serial_clock_pin) |-> $stable(latch_pin))
		else $error("latch moved while clock high");
	frame_bits_a: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(latch_pin) |-> bitCnt == 6'h20 || bitCnt == 6'h08)
		else $error("frame bit count not 32 or 8");
	two_pulses_a: assert property (@(posedge clk_sys) disable iff (reset)
		clockRise && !latch_pin |-> pulseCnt < 2'h2)
		else $error("more than two pulses after latch low");
	pulses_done_a: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(latch_pin) && framed |-> pulseCnt == 2'h2)
		else $error("latch raised before two pulses");
	ready_high_a: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(latch_pin) |-> resp_out_pin)
		else $error("latch raised while response low");
	busy_low_a: assert property (@(posedge clk_sys) disable iff (reset)
		clockRise && !latch_pin && pulseCnt == 2'h1 && isWrite |-> !resp_out_pin)
		else $error("response not low by second pulse of write");
endmodule : sepp_link_sva

// file: tb/tb_top.sv
/*
 * Bench joining programmer and device ends through the link interface.
 * Assumes the design files and sepp_defines.svh are compiled first.
 */
`timescale 1ns/10ps
`include "sepp_defines.svh"

module tb_top;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic byteOnly = 1'b0;
	logic [31:0] cmdWord = 32'h00000000;
	logic progMode, writeStrobe, ready, done;
	logic [`SEPP_ADDR_BITS-1:0] writeAddr;
	logic [`SEPP_BYTE_BITS-1:0] writeData;
	logic [31:0] respWord;
	logic [9:0] addrQ[$];
	logic [7:0] dataQ[$];
	int n_fail = 0;
	int n_checks = 0;
	int cycles = 0;

	sepp_if link();
	sepp_device sepp_device_inst (.clk_sys(clk_sys), .reset(reset),
		.link(link), .progMode(progMode), .writeStrobe(writeStrobe),
		.writeAddr(writeAddr), .writeData(writeData));
	sepp_programmer sepp_programmer_inst (.clk_sys(clk_sys), .reset(reset),
		.link(link), .start(start), .byteOnly(byteOnly), .cmdWord(cmdWord),
		.ready(ready), .done(done), .respWord(respWord));
	sepp_link_sva sepp_link_sva_inst (.clk_sys(clk_sys), .reset(reset),
		.latch_pin(link.latch_pin), .cmd_in_pin(link.cmd_in_pin),
		.resp_out_pin(link.resp_out_pin),
		.serial_clock_pin(link.serial_clock_pin));

	always #2 clk_sys = ~clk_sys;

	// ****************************************************************
	// memory write monitor and hang guard
	// ****************************************************************
	always @(negedge clk_sys) if (writeStrobe === 1'b1) begin
		addrQ.push_back(writeAddr);
		dataQ.push_back(writeData);
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 32'h00007530) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [31:0] mk(input logic page,
		input logic [12:0] op, input logic [9:0] a, input logic [7:0] d);
		return {page, op, a, d};
	endfunction : mk

	task send(input logic only, input logic [31:0] word,
		output logic [31:0] resp);
		int k;
		@(negedge clk_sys);
		start = 1'b1;
		byteOnly = only;
		cmdWord = word;
		for (k = 0; k < 32'h1388 && ready !== 1'b0; k++) @(negedge clk_sys);
		start = 1'b0;
		for (k = 0; k < 32'h1388 && done !== 1'b1; k++) @(negedge clk_sys);
		check({31'h0, done}, 32'h1);
		check({31'h0, ready}, 32'h1);
		resp = respWord;
	endtask : send

	task byte_write(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] r;
		addrQ.delete();
		dataQ.delete();
		send(1'b0, mk(1'b0, `SEPP_OP_WRITE, a, d), r);
		check(32'(addrQ.size()), 32'h1);
		check({22'h0, addrQ[0]}, {22'h0, a});
		check({24'h0, dataQ[0]}, {24'h0, d});
		check({31'h0, progMode}, 32'h1);
	endtask : byte_write

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task tb_byte_write;
		byte_write(10'h2C3, 8'h1E);
	endtask : tb_byte_write

	task tb_read_back;
		logic [31:0] r;
		addrQ.delete();
		send(1'b0, mk(1'b0, `SEPP_OP_READ, 10'h2C3, 8'h00), r);
		check(r, `SEPP_RESP_OK);
		send(1'b0, mk(1'b0, `SEPP_OP_READ, 10'h155, 8'h00), r);
		check({24'h0, r[7:0]}, 32'h1E);
		check(32'(addrQ.size()), 32'h0);
	endtask : tb_read_back

	task tb_page_write;
		logic [31:0] r;
		logic [7:0] b;
		int i;
		addrQ.delete();
		dataQ.delete();
		send(1'b0, mk(1'b1, `SEPP_OP_WRITE, 10'h020, 8'h40), r);
		for (i = 1; i < 16; i++) begin
			check(32'(addrQ.size()), 32'h0);
			b = 8'h40 + 8'(i);
			send(1'b1, {24'h0, b}, r);
		end
		check(32'(addrQ.size()), 32'h10);
		for (i = 0; i < 16; i++) begin
			check({22'h0, addrQ[i]}, 32'h20 + 32'(i));
			check({24'h0, dataQ[i]}, 32'h40 + 32'(i));
		end
	endtask : tb_page_write

	task tb_reset_mid;
		@(negedge clk_sys);
		reset = 1'b1;
		@(negedge clk_sys);
		check({31'h0, progMode}, 32'h0);
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		repeat (2) @(negedge clk_sys);
		check({31'h0, progMode}, 32'h1);
		byte_write(10'h3FF, 8'h81);
	endtask : tb_reset_mid

	initial begin
		repeat (3) @(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		tb_byte_write();
		tb_read_back();
		tb_page_write();
		tb_reset_mid();
		report_and_stop();
	end
endmodule : tb_top
